// *** fidq_consts.svh ***
`ifndef FIDQ_CONSTS_SVH
`define FIDQ_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define FIDQ_CLK_PS 8000
`define FIDQ_T_ACC_NS 110
`define FIDQ_ACC_CYC ((`FIDQ_T_ACC_NS * 1000 + `FIDQ_CLK_PS - 1) / `FIDQ_CLK_PS)

// ****************************************
// software register byte offsets
// ****************************************
`define FIDQ_REG_CTRL 8'h00
`define FIDQ_REG_SECTOR 8'h04
`define FIDQ_REG_STATUS 8'h08
`define FIDQ_REG_WORD0 8'h0c
`define FIDQ_WORD_COUNT 6

// ****************************************
// status bit positions
// ****************************************
`define FIDQ_ST_BUSY 0
`define FIDQ_ST_DONE 1
`define FIDQ_ST_PROT 2
`define FIDQ_ST_FACTORY 3
`define FIDQ_ST_CUSTOMER 4
`define FIDQ_ST_GUARD 5
`define FIDQ_ST_IND_OK 6

// ****************************************
// flash address map and commands
// ****************************************
`define FIDQ_SEC_W 11
`define FIDQ_ADDR_W 27
`define FIDQ_DIE_BIT 26
`define FIDQ_UNLOCK1_ADDR 26'h0000555
`define FIDQ_UNLOCK2_ADDR 26'h00002aa
`define FIDQ_UNLOCK1_DATA 16'h00aa
`define FIDQ_UNLOCK2_DATA 16'h0055
`define FIDQ_ENTRY_OFS 16'h0555
`define FIDQ_ENTRY_DATA 16'h0090
`define FIDQ_EXIT_DATA 16'h00f0
`define FIDQ_PROT_OFS 4'h2
`define FIDQ_FIRST_READ 4'h3
`define FIDQ_LAST_STEP 4'h9

// ****************************************
// indicator word layout
// ****************************************
`define FIDQ_IND_FACTORY 7
`define FIDQ_IND_CUSTOMER 6
`define FIDQ_IND_GUARD 4
`define FIDQ_IND_RSVD_MASK 16'hff2f

`endif

// *** fidq_flash_model.sv ***
module fidq_flash_model
    import fidq_pkg::*;
#(
    parameter int acc_ns = 96,
    parameter logic [15:0] maker_id = 16'h00c3, // arbitrary value
    parameter logic [15:0] dev_id1 = 16'h4a10, // arbitrary value
    parameter logic [15:0] dev_id2 = 16'h4a21, // arbitrary value
    parameter logic [15:0] dev_id3 = 16'h4a32 // arbitrary value
)
(
    input wire logic [26:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic [10:0] prot_sector,
    input wire logic factory_lock,
    input wire logic customer_lock,
    input wire logic guard_high,
    output logic [15:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] step;
    logic in_overlay;
    logic die;
    logic ready;
    logic [10:0] sel;
    logic [15:0] word;
    logic [15:0] last = 16'h0;
    // commands count only once data has settled behind the falling strobe
    always @(negedge we_n or negedge reset_n)
    begin
        if (!reset_n)
        begin
            step = 0;
            in_overlay = 0;
        end
        else
        begin
            #1;
            if (!ce_n && dq_oe)
            begin
                if (dq_out[7:0] == 8'hf0)
                begin
                    in_overlay = 0;
                    step = 0;
                end
                else if (step == 0 && addr[15:0] == 16'h0555 && dq_out[7:0] == 8'haa)
                begin
                    step = 1;
                    die = addr[26];
                end
                else if (step == 1 && addr[15:0] == 16'h02aa && addr[26] == die)
                    step = 2;
                else if (step == 2 && dq_out[7:0] == 8'h90 && addr[26] == die)
                begin
                    in_overlay = 1;
                    sel = addr[26:16];
                    step = 0;
                end
                else
                    step = 0;
            end
        end
    end
    always @*
    begin
        word = addr[15:0] ^ 16'h5a5a;
        if (in_overlay && addr[26:16] != sel)
            word = ~last;
        else if (in_overlay)
            // every overlay word, the protection word among them, follows the address once ready, with no fresh chip enable fall
            case (addr[15:0])
                16'h0: word = maker_id;
                16'h1: word = dev_id1;
                16'h2: word = {15'h0, sel == prot_sector};
                16'h3: word = {8'hff, factory_lock, customer_lock, 1'b1, guard_high, 4'hf};
                16'he: word = dev_id2;
                16'hf: word = dev_id3;
                default: word = 16'hffff;
            endcase
    end
    // data only after a fresh chip enable fall plus the full access time
    always @(negedge ce_n)
    begin
        ready = 0;
        #(acc_ns);
        ready = !ce_n;
        last = word;
    end
    always @(posedge ce_n)
        ready = 0;
    assign dq_in = (!ce_n && !oe_n && ready) ? word : ~last;
endmodule

// *** fidq_host.sv ***
`include "fidq_consts.svh"

// Overview of operation
// - each sector query enters the overlay with its address and exits afterwards.
// - chip enable goes high before each read and low again to start it.
// - no page-mode reads; every read is its own chip enable cycle.
// - protection offset is read only inside the selected sector; others discarded.
// - die select address bit follows the sector address in all command cycles.
module fidq_host
    import fidq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [26:0] flash_addr,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n
);

    localparam int ACC = `FIDQ_ACC_CYC;

    fidq_state_type state;
    fidq_state_type next_state;
    logic [3:0] step;
    logic [4:0] cnt;
    logic busy;
    logic done;
    logic [`FIDQ_SEC_W-1:0] sector;
    logic [15:0] id_word [`FIDQ_WORD_COUNT];

    // ****************************************
    // step table
    // ****************************************
    function automatic fidq_step_type step_info(input logic [3:0] idx,
                                                input logic [`FIDQ_SEC_W-1:0] sec);
        fidq_step_type s;
        logic [26:0] base;
        s = '0;
        base = {sec, 16'h0000};
        // die bit rides on every command cycle, unlock included
        case (idx)
            4'h0: s = '{1'b1, {sec[`FIDQ_SEC_W-1], `FIDQ_UNLOCK1_ADDR}, `FIDQ_UNLOCK1_DATA};
            4'h1: s = '{1'b1, {sec[`FIDQ_SEC_W-1], `FIDQ_UNLOCK2_ADDR}, `FIDQ_UNLOCK2_DATA};
            4'h2: s = '{1'b1, base | {11'h000, `FIDQ_ENTRY_OFS}, `FIDQ_ENTRY_DATA};
            4'h3: s = '{1'b0, base | 27'h0000000, 16'h0000};
            4'h4: s = '{1'b0, base | 27'h0000001, 16'h0000};
            4'h5: s = '{1'b0, base | {23'h000000, `FIDQ_PROT_OFS}, 16'h0000};
            4'h6: s = '{1'b0, base | 27'h0000003, 16'h0000};
            4'h7: s = '{1'b0, base | 27'h000000e, 16'h0000};
            4'h8: s = '{1'b0, base | 27'h000000f, 16'h0000};
            4'h9: s = '{1'b1, base, `FIDQ_EXIT_DATA};
            default: s = '0;
        endcase
        return s;
    endfunction

    // ****************************************
    // software port decode
    // ****************************************
    wire start_hit = reg_wr && reg_addr == `FIDQ_REG_CTRL && reg_wdata[0] && !busy;
    wire sector_hit = reg_wr && reg_addr == `FIDQ_REG_SECTOR && !busy;
    fidq_step_type cur;
    fidq_step_type next_cur;
    assign cur = step_info(step, sector);
    // entry to the next step: the step after the current one, or the first after idle
    assign next_cur = step_info(state == FIDQ_GAP ? step + 4'h1 : 4'h0, sector);
    wire pulse_end = state == FIDQ_PULSE && cnt == 5'(ACC - 1);
    wire last_step = step == `FIDQ_LAST_STEP;
    wire [15:0] ind = id_word[3];
    // reserved bits forced to one mean the indicator is plausible
    wire ind_ok = (ind & `FIDQ_IND_RSVD_MASK) == `FIDQ_IND_RSVD_MASK;
    wire [31:0] status = {25'h0000000, ind_ok,
        ind[`FIDQ_IND_GUARD],
        ind[`FIDQ_IND_CUSTOMER],
        ind[`FIDQ_IND_FACTORY],
        id_word[2][0],
        done, busy};
    wire [7:0] word_ofs = reg_addr - `FIDQ_REG_WORD0;
    wire word_sel = reg_addr >= `FIDQ_REG_WORD0 && word_ofs[7:2] < 6'(`FIDQ_WORD_COUNT)
        && word_ofs[1:0] == 2'b00;
    wire [31:0] rd_mux = reg_addr == `FIDQ_REG_SECTOR ? {21'h000000, sector} :
        reg_addr == `FIDQ_REG_STATUS ? status :
        word_sel ? {16'h0000, id_word[word_ofs[4:2]]} : 32'h00000000;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        next_state = state;
        case (state)
            FIDQ_IDLE: if (start_hit) next_state = FIDQ_SETUP;
            FIDQ_SETUP: next_state = FIDQ_PULSE;
            FIDQ_PULSE: if (pulse_end) next_state = FIDQ_GAP;
            // chip enable high between every access, so no page mode ever forms
            FIDQ_GAP: next_state = last_step ? FIDQ_IDLE : FIDQ_SETUP;
            default: next_state = FIDQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= FIDQ_IDLE;
            step <= 4'h0;
            cnt <= 5'h00;
            busy <= 1'b0;
            done <= 1'b0;
            sector <= '0;
            reg_rdata <= 32'h00000000;
            flash_reset_n <= 1'b0;
        end
        else
        begin
            state <= next_state;
            // full access time on every read, protection word included
            cnt <= state == FIDQ_PULSE && !pulse_end ? cnt + 5'h01 : 5'h00;
            if (state == FIDQ_IDLE)
                step <= 4'h0;
            else if (state == FIDQ_GAP)
                step <= step + 4'h1;
            // every run enters and exits, so a new sector needs a new run
            busy <= next_state != FIDQ_IDLE;
            if (start_hit)
                done <= 1'b0;
            else if (state == FIDQ_GAP && last_step)
                done <= 1'b1;
            if (sector_hit)
                sector <= reg_wdata[`FIDQ_SEC_W-1:0];
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
            flash_reset_n <= 1'b1;
        end
    end

    // ****************************************
    // flash pins
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_addr <= '0;
            flash_dq_out <= 16'h0000;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end
        else
        begin
            if (next_state == FIDQ_SETUP)
                flash_addr <= next_cur.addr;
            flash_dq_out <= cur.data;
            flash_dq_oe <= next_state == FIDQ_PULSE && cur.is_write;
            flash_ce_n <= next_state != FIDQ_PULSE;
            flash_oe_n <= !(next_state == FIDQ_PULSE && !cur.is_write);
            flash_we_n <= !(next_state == FIDQ_PULSE && cur.is_write);
        end
    end

    // ****************************************
    // captured overlay words
    // ****************************************
    generate
        for (genvar i = 0; i < `FIDQ_WORD_COUNT; i++)
        begin : g_cap
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    id_word[i] <= 16'h0000;
                else if (pulse_end && !cur.is_write && step == `FIDQ_FIRST_READ + 4'(i))
                    id_word[i] <= flash_dq_in;
            end
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    logic [4:0] low_cnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            low_cnt <= 5'h00;
        else
            low_cnt <= flash_ce_n ? 5'h00 : low_cnt + 5'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        reg_wr && reg_addr == `FIDQ_REG_CTRL && reg_wdata[0] && !busy;
    endsequence
    sequence s_first_unlock;
        !flash_ce_n && !flash_we_n && flash_dq_out == `FIDQ_UNLOCK1_DATA;
    endsequence

    a_access_length: assert property ($rose(flash_ce_n) |-> low_cnt == 5'(ACC))
        else $error("chip enable low time differs from access time");
    a_ce_gap: assert property ($fell(flash_ce_n) |-> $past(flash_ce_n, 2))
        else $error("chip enable not high before access");
    a_no_page_move: assert property (!flash_ce_n && !$fell(flash_ce_n) |-> $stable(flash_addr))
        else $error("address moved inside one access");
    a_die_bit: assert property (!flash_ce_n |-> flash_addr[26] == sector[10])
        else $error("die select bit disagrees with sector");
    a_read_in_sector: assert property (!flash_oe_n |-> flash_addr[26:16] == sector)
        else $error("overlay read outside selected sector");
    a_start_unlock: assert property (s_start |=> ##1 s_first_unlock)
        else $error("run did not open with unlock cycle");
    a_exit_last: assert property ($fell(busy) |-> $past(step) == `FIDQ_LAST_STEP)
        else $error("run ended without exit command");
    a_prot_flag: assert property (pulse_end && !flash_oe_n && flash_addr[3:0] == `FIDQ_PROT_OFS
        |=> id_word[2] == $past(flash_dq_in))
        else $error("protection word not captured at end of its read");

endmodule

// *** fidq_host_test.sv ***
`include "fidq_consts.svh"
module fidq_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, reg_wr, reg_rd, dq_oe, ce_n, oe_n, we_n, frst_n, fl, cl, gh;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [26:0] faddr;
    logic [15:0] din, dout, ind;
    logic [10:0] psec;
    logic [15:0] exp_w [6];
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [10:0] secs [5] = '{11'h405, 11'h012, 11'h7ff, 11'h000, 11'h3ff};
    logic [3:0] cfg [5] = '{4'b1001, 4'b0101, 4'b1010, 4'b0100, 4'b1000};
    fidq_host dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(faddr),
        .flash_dq_in(din), .flash_dq_out(dout), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(frst_n));
    fidq_flash_model #(.acc_ns(`FIDQ_T_ACC_NS)) flash_u (.addr(faddr), .dq_out(dout),
        .dq_oe(dq_oe), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .reset_n(frst_n), .prot_sector(psec), .factory_lock(fl),
        .customer_lock(cl), .guard_high(gh), .dq_in(din));
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 9000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    initial
    begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {psec, fl, cl, gh} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
        begin
            psec <= (i % 2 == 0) ? secs[i] : 11'h155;
            {fl, cl, gh} <= cfg[i][2:0];
            wr(`FIDQ_REG_SECTOR, {21'h0, secs[i]});
            wr(`FIDQ_REG_CTRL, 32'h1);
            wr(`FIDQ_REG_SECTOR, 32'h2aa);
            v = 32'h1;
            for (int n = 0; n < 300 && v[`FIDQ_ST_BUSY]; n++)
                rd(`FIDQ_REG_STATUS, v);
            ind = {8'hff, cfg[i][2:1], 1'b1, cfg[i][0], 4'hf};
            check(v, {25'h0, 1'b1, cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3], 2'b10});
            rd(`FIDQ_REG_SECTOR, v);
            check(v, {21'h0, secs[i]});
            exp_w = '{16'h00c3, 16'h4a10, {15'h0, cfg[i][3]}, ind, 16'h4a21, 16'h4a32};
            for (int k = 0; k < 6; k++)
            begin
                rd(`FIDQ_REG_WORD0 + 8'(4 * k), v);
                check(v, {16'h0, exp_w[k]});
            end
        end
        rd(8'hfc, v);
        check(v, 32'h0);
        report_and_stop();
    end
endmodule

// *** fidq_pkg.sv ***
package fidq_pkg;

    typedef enum logic [1:0] {
        FIDQ_IDLE,
        FIDQ_SETUP,
        FIDQ_PULSE,
        FIDQ_GAP
    } fidq_state_type;

    typedef struct packed {
        logic is_write;
        logic [26:0] addr;
        logic [15:0] data;
    } fidq_step_type;

endpackage
